// file: seb_counter_bank.sv
// Bank of eight signed event counters with a classic Wishbone slave.
`timescale 1ns/1ps
module seb_counter_bank (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [seb_pkg::SEB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input seb_pkg::seb_cnt_in_t [seb_pkg::SEB_NUM-1:0] cnt_in_i,
    input wire logic [seb_pkg::SEB_TSW-1:0] timestamp_i,
    output seb_pkg::seb_flags_t [seb_pkg::SEB_NUM-1:0] flags_o,
    input wire logic power_fail_i,
    output seb_pkg::seb_nv_word_t nv_save_o,
    output logic nv_save_done_o,
    input seb_pkg::seb_nv_word_t nv_restore_i
);
    import seb_pkg::*;

    typedef struct packed {
        logic [31:0] count;
        logic [31:0] cap_count;
        logic [63:0] cap_ts;
        logic en_prev;
        logic up_prev;
        logic down_prev;
        logic sel_prev;
        logic cc_prev;
        logic ck_prev;
        seb_flags_t flags;
    } seb_ch_state_t;

    typedef struct packed {
        seb_ch_state_t [SEB_NUM-1:0] ch;
        logic [SEB_NUM-1:0][31:0] preset;
        logic [SEB_NUM-1:0][31:0] thresh;
        logic [SEB_NUM-1:0][31:0] units;
        logic [SEB_NUM-1:0] enable;
        logic [SEB_IRQ_W-1:0] irq_stat;
        logic [SEB_IRQ_W-1:0] irq_mask;
        logic [31:0] rdata;
        logic ack;
        logic irq;
    } seb_top_state_t;

    seb_top_state_t st_r;
    seb_top_state_t st_nxt;

    logic [SEB_NUM-1:0] up_e;
    logic [SEB_NUM-1:0] down_e;
    logic [SEB_NUM-1:0] sel_e;
    logic [SEB_NUM-1:0] cc_e;
    logic [SEB_NUM-1:0] ck_e;
    logic [SEB_NUM-1:0][31:0] init_val;
    logic [SEB_NUM-1:0] capt_ev;
    logic [SEB_NUM-1:0] wrap_ev;
    logic [SEB_NV_AW-1:0] nv_addr;
    logic [31:0] nv_word;
    logic wr_go;
    logic [31:0] stat_clr;
    logic [31:0] mask_new;

    // [RULE_15] Edges against the previous sample.
    for (genvar g = 0; g < SEB_NUM; g++) begin : g_edge
        assign up_e[g] = cnt_in_i[g].up & ~st_r.ch[g].up_prev;
        assign down_e[g] = cnt_in_i[g].down & ~st_r.ch[g].down_prev;
        assign sel_e[g] = cnt_in_i[g].load_initial_select &
            ~st_r.ch[g].sel_prev;
        assign cc_e[g] = cnt_in_i[g].capture_clear & ~st_r.ch[g].cc_prev;
        assign ck_e[g] = cnt_in_i[g].capture_keep & ~st_r.ch[g].ck_prev;
        // [RULE_09] Start value follows the select level.
        assign init_val[g] = cnt_in_i[g].load_initial_select ?
            st_r.preset[g] : SEB_ZERO;
        assign flags_o[g] = st_r.ch[g].flags;
    end

    function automatic logic [31:0] seb_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : seb_merge

    // [RULE_12] Live and captured values in the read map.
    function automatic logic [31:0] seb_read(input seb_top_state_t s,
                                             input logic [11:0] adr);
        logic [31:0] res;
        logic [2:0] c;
        res = SEB_ZERO;
        c = adr[7:5];
        if (adr[11:8] == SEB_OFS_CH_PAGE) begin
            case (adr[4:0])
                SEB_CH_PRESET: res = s.preset[c];
                SEB_CH_THRESH: res = s.thresh[c];
                // [RULE_14] Unit label reads back beside the count.
                SEB_CH_UNITS: res = s.units[c];
                SEB_CH_COUNT: res = s.ch[c].count;
                SEB_CH_CAP_COUNT: res = s.ch[c].cap_count;
                SEB_CH_CAP_TS_LO: res = s.ch[c].cap_ts[31:0];
                SEB_CH_CAP_TS_HI: res = s.ch[c].cap_ts[63:32];
                default: res = SEB_ZERO;
            endcase
        end else begin
            case (adr)
                SEB_OFS_ENABLE: res = {24'h000000, s.enable};
                SEB_OFS_IRQ_STAT: res = {16'h0000, s.irq_stat};
                SEB_OFS_IRQ_MASK: res = {16'h0000, s.irq_mask};
                SEB_OFS_FLAGS: begin
                    for (int i = 0; i < SEB_NUM; i++) begin
                        res[i*3 +: 3] = s.ch[i].flags;
                    end
                end
                default: res = SEB_ZERO;
            endcase
        end
        return res;
    endfunction : seb_read

    // [RULE_13] Storage word for one counter field.
    function automatic logic [31:0] seb_nv_pick(input seb_top_state_t s,
                                                input logic [4:0] a);
        logic [31:0] res;
        case (a[1:0])
            SEB_NV_COUNT: res = s.ch[a[4:2]].count;
            SEB_NV_CAP: res = s.ch[a[4:2]].cap_count;
            SEB_NV_TS_LO: res = s.ch[a[4:2]].cap_ts[31:0];
            default: res = s.ch[a[4:2]].cap_ts[63:32];
        endcase
        return res;
    endfunction : seb_nv_pick

    assign nv_word = seb_nv_pick(st_r, nv_addr);
    assign wr_go = st_r.ack & wb_cyc_i & wb_stb_i & wb_we_i;
    assign stat_clr = seb_merge(SEB_ZERO, wb_dat_i, wb_sel_i);
    assign mask_new = seb_merge({16'h0000, st_r.irq_mask}, wb_dat_i, wb_sel_i);

    always_comb begin
        st_nxt = st_r;
        capt_ev = '0;
        wrap_ev = '0;
        // [RULE_01] Every counter runs the same step independently.
        for (int i = 0; i < SEB_NUM; i++) begin
            st_nxt.ch[i].up_prev = cnt_in_i[i].up;
            st_nxt.ch[i].down_prev = cnt_in_i[i].down;
            st_nxt.ch[i].sel_prev = cnt_in_i[i].load_initial_select;
            st_nxt.ch[i].cc_prev = cnt_in_i[i].capture_clear;
            st_nxt.ch[i].ck_prev = cnt_in_i[i].capture_keep;
            st_nxt.ch[i].en_prev = st_r.enable[i];
            if (st_r.enable[i] && !st_r.ch[i].en_prev) begin
                // [RULE_07] Enable loads preset or zero.
                st_nxt.ch[i].count = init_val[i];
            end else if (st_r.enable[i]) begin
                if (cc_e[i]) begin
                    // [RULE_10] Capture then clear.
                    st_nxt.ch[i].cap_count = st_r.ch[i].count;
                    st_nxt.ch[i].cap_ts = timestamp_i;
                    st_nxt.ch[i].count = init_val[i];
                    capt_ev[i] = 1'b1;
                end else if (cnt_in_i[i].clear_cmd) begin
                    // [RULE_09] Reset command load.
                    st_nxt.ch[i].count = init_val[i];
                end else if (sel_e[i]) begin
                    // [RULE_08] Rising select loads preset.
                    st_nxt.ch[i].count = st_r.preset[i];
                end else if (!cnt_in_i[i].inhibit && (up_e[i] ^ down_e[i])) begin
                    // [RULE_02] Count on edges only.
                    if (up_e[i]) begin
                        // [RULE_04] Up wraps past the top.
                        if (st_r.ch[i].count == SEB_CNT_MAX) begin
                            st_nxt.ch[i].count = SEB_CNT_MIN;
                            wrap_ev[i] = 1'b1;
                        end else begin
                            st_nxt.ch[i].count = st_r.ch[i].count + SEB_ONE;
                        end
                    end else begin
                        // [RULE_05] Down wraps past the bottom.
                        if (st_r.ch[i].count == SEB_CNT_MIN) begin
                            st_nxt.ch[i].count = SEB_CNT_MAX;
                            wrap_ev[i] = 1'b1;
                        end else begin
                            st_nxt.ch[i].count = st_r.ch[i].count - SEB_ONE;
                        end
                    end
                end
                if (ck_e[i] && !cc_e[i]) begin
                    // [RULE_11] Capture while counting goes on.
                    st_nxt.ch[i].cap_count = st_r.ch[i].count;
                    st_nxt.ch[i].cap_ts = timestamp_i;
                    capt_ev[i] = 1'b1;
                end
            end
            if (nv_restore_i.we && (nv_restore_i.addr[4:2] == 3'(i))) begin
                case (nv_restore_i.addr[1:0])
                    SEB_NV_COUNT: st_nxt.ch[i].count = nv_restore_i.data;
                    SEB_NV_CAP: st_nxt.ch[i].cap_count = nv_restore_i.data;
                    SEB_NV_TS_LO: st_nxt.ch[i].cap_ts[31:0] = nv_restore_i.data;
                    default: st_nxt.ch[i].cap_ts[63:32] = nv_restore_i.data;
                endcase
            end
            // [RULE_16] Flags from the updated signed count.
            st_nxt.ch[i].flags = '0;
            // [RULE_06] Inhibit blocks flags.
            if (st_r.enable[i] && !cnt_in_i[i].inhibit) begin
                // [RULE_03] Exactly one of three flags.
                st_nxt.ch[i].flags.count_above_threshold =
                    $signed(st_nxt.ch[i].count) > $signed(st_r.thresh[i]);
                st_nxt.ch[i].flags.count_matches_threshold =
                    st_nxt.ch[i].count == st_r.thresh[i];
                st_nxt.ch[i].flags.count_under_threshold =
                    $signed(st_nxt.ch[i].count) < $signed(st_r.thresh[i]);
            end
        end
        st_nxt.ack = wb_cyc_i & wb_stb_i & ~st_r.ack;
        if (wb_cyc_i && wb_stb_i && !st_r.ack) begin
            st_nxt.rdata = seb_read(st_r, wb_adr_i);
        end
        st_nxt.irq_stat = st_r.irq_stat;
        if (wr_go) begin
            if (wb_adr_i[11:8] == SEB_OFS_CH_PAGE) begin
                case (wb_adr_i[4:0])
                    SEB_CH_PRESET: st_nxt.preset[wb_adr_i[7:5]] =
                        seb_merge(st_r.preset[wb_adr_i[7:5]], wb_dat_i,
                                  wb_sel_i);
                    SEB_CH_THRESH: st_nxt.thresh[wb_adr_i[7:5]] =
                        seb_merge(st_r.thresh[wb_adr_i[7:5]], wb_dat_i,
                                  wb_sel_i);
                    // [RULE_14] Software assigns the unit label.
                    SEB_CH_UNITS: st_nxt.units[wb_adr_i[7:5]] =
                        seb_merge(st_r.units[wb_adr_i[7:5]], wb_dat_i,
                                  wb_sel_i);
                    default: ;
                endcase
            end else begin
                case (wb_adr_i)
                    SEB_OFS_ENABLE: begin
                        if (wb_sel_i[0]) begin
                            st_nxt.enable = wb_dat_i[7:0];
                        end
                    end
                    SEB_OFS_IRQ_STAT: begin
                        st_nxt.irq_stat = st_r.irq_stat & ~stat_clr[15:0];
                    end
                    SEB_OFS_IRQ_MASK: begin
                        st_nxt.irq_mask = mask_new[15:0];
                    end
                    default: ;
                endcase
            end
        end
        // A new event in the clearing cycle stays set.
        st_nxt.irq_stat = st_nxt.irq_stat | {wrap_ev, capt_ev};
        st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
            for (int i = 0; i < SEB_NUM; i++) begin
                st_r.preset[i] <= SEB_PRESET_RST;
                st_r.thresh[i] <= SEB_THRESH_RST;
                st_r.units[i] <= SEB_UNITS_RST;
            end
            st_r.enable <= SEB_ENABLE_RST;
            st_r.irq_mask <= SEB_MASK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    seb_nv_save u_nv_save (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .power_fail_i(power_fail_i),
        .word_i(nv_word),
        .addr_o(nv_addr),
        .nv_o(nv_save_o),
        .done_o(nv_save_done_o)
    );

    assign wb_dat_o = st_r.rdata;
    assign wb_ack_o = st_r.ack;
    assign irq_o = st_r.irq;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_irq_level: assert property (irq_o == |(st_r.irq_stat & st_r.irq_mask))
        else $error("Interrupt does not follow masked status.");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Bus acknowledge lasted more than one cycle.");

    for (genvar g = 0; g < SEB_NUM; g++) begin : g_chk
        logic quiet;
        assign quiet = st_r.enable[g] & st_r.ch[g].en_prev & ~cc_e[g] &
            ~cnt_in_i[g].clear_cmd & ~sel_e[g] & ~cnt_in_i[g].inhibit &
            ~nv_restore_i.we;
        a_up_step: assert property ( // [RULE_02]
            quiet && up_e[g] && !down_e[g] &&
            st_r.ch[g].count != SEB_CNT_MAX
            |=> st_r.ch[g].count == $past(st_r.ch[g].count) + SEB_ONE)
            else $error("Rising up edge did not add one.");
        a_steady_high: assert property ( // [RULE_15]
            quiet && !(up_e[g] ^ down_e[g]) && !ck_e[g]
            |=> $stable(st_r.ch[g].count))
            else $error("Count moved without a single edge.");
        a_wrap_top: assert property ( // [RULE_04]
            quiet && up_e[g] && !down_e[g] &&
            st_r.ch[g].count == SEB_CNT_MAX
            |=> st_r.ch[g].count == SEB_CNT_MIN && st_r.irq_stat[g + 8])
            else $error("Up count at top did not wrap.");
        a_wrap_bottom: assert property ( // [RULE_05]
            quiet && down_e[g] && !up_e[g] &&
            st_r.ch[g].count == SEB_CNT_MIN
            |=> st_r.ch[g].count == SEB_CNT_MAX)
            else $error("Down count at bottom did not wrap.");
        a_flags_onehot: assert property ( // [RULE_03]
            st_r.enable[g] && !cnt_in_i[g].inhibit
            |=> $onehot(st_r.ch[g].flags))
            else $error("Threshold flags not exactly one.");
        a_inhibit_flags: assert property ( // [RULE_06]
            cnt_in_i[g].inhibit |=> st_r.ch[g].flags == 3'b000)
            else $error("Flags active while inhibited.");
        a_enable_load: assert property ( // [RULE_07]
            st_r.enable[g] && !st_r.ch[g].en_prev && !nv_restore_i.we
            |=> st_r.ch[g].count == $past(init_val[g]))
            else $error("Enable did not load start value.");
        a_select_edge: assert property ( // [RULE_08]
            st_r.enable[g] && st_r.ch[g].en_prev && sel_e[g] && !cc_e[g] &&
            !cnt_in_i[g].clear_cmd && !nv_restore_i.we
            |=> st_r.ch[g].count == $past(st_r.preset[g]))
            else $error("Rising select did not load preset.");
        a_clear_load: assert property ( // [RULE_09]
            st_r.enable[g] && st_r.ch[g].en_prev && !cc_e[g] &&
            cnt_in_i[g].clear_cmd && !nv_restore_i.we
            |=> st_r.ch[g].count == $past(init_val[g]))
            else $error("Reset command loaded wrong value.");
        a_cap_clear: assert property ( // [RULE_10]
            st_r.enable[g] && st_r.ch[g].en_prev && cc_e[g] &&
            !nv_restore_i.we
            |=> st_r.ch[g].cap_count == $past(st_r.ch[g].count) &&
                st_r.ch[g].cap_ts == $past(timestamp_i) &&
                st_r.ch[g].count == $past(init_val[g]))
            else $error("Capture and clear went wrong.");
        a_cap_keep: assert property ( // [RULE_11]
            quiet && ck_e[g] && !up_e[g] && !down_e[g]
            |=> st_r.ch[g].cap_count == $past(st_r.ch[g].count) &&
                $stable(st_r.ch[g].count))
            else $error("Capture and continue disturbed count.");
        a_match_flag: assert property ( // [RULE_16]
            st_r.enable[g] && !cnt_in_i[g].inhibit
            |=> st_r.ch[g].flags.count_matches_threshold ==
                (st_r.ch[g].count == $past(st_r.thresh[g])))
            else $error("Match flag disagrees with count.");
        c_wrap: cover property (quiet && up_e[g] &&
            st_r.ch[g].count == SEB_CNT_MAX);
        c_cap_clear: cover property (st_r.enable[g] && cc_e[g]);
    end

    a_nv_burst: assert property ( // [RULE_13]
        $rose(nv_save_o.we) |-> nv_save_o.we [*8])
        else $error("Save burst broke off early.");
    c_nv_done: cover property ($rose(nv_save_done_o));
    c_irq: cover property ($rose(irq_o));

endmodule : seb_counter_bank

// file: seb_pkg.sv
// Constants, types and state encodings for the signed event counter bank.
// How it works
// [RULE_01] Eight identical counters, each with its own inputs, settings and outputs.
// [RULE_02] Counting happens only on low-to-high input transitions, never on steady highs.
// [RULE_03] Three exclusive flags show count above, equal to or under threshold.
// [RULE_04] Counting up from the largest positive value wraps to the most negative.
// [RULE_05] Counting down from the most negative value wraps to the largest positive.
// [RULE_06] Inhibit ignores count events and forces all three flags low.
// [RULE_07] On enabling, count loads preset if select is high, else zero.
// [RULE_08] While running, a rising select loads preset; a falling select does nothing.
// [RULE_09] Reset or capture-and-clear loads preset if select is high, else zero.
// [RULE_10] Capture-and-clear stores count and timestamp, then clears the running count.
// [RULE_11] Capture-and-continue stores count and timestamp and counting carries on.
// [RULE_12] Live count, captured count and its timestamp are all readable.
// [RULE_13] On power failure live and captured values are written to storage.
// [RULE_14] Each counter keeps a writable unit label that reads back with status; the code reads it back in the counter page beside the count.
// [RULE_15] One clock samples all inputs; simultaneous up and down edges cancel.
// [RULE_16] Values are 32-bit signed; flags reflect the count after same-cycle update.
package seb_pkg;

    localparam int SEB_NUM = 8;
    localparam int SEB_CW = 32;
    localparam int SEB_TSW = 64;
    localparam int SEB_ADR_W = 12;
    localparam int SEB_NV_AW = 5;
    localparam int SEB_IRQ_W = 16;
    localparam int SEB_IRQ_CAPT_LSB = 0;
    localparam int SEB_IRQ_WRAP_LSB = 8;

    localparam logic [31:0] SEB_CNT_MAX = 32'h7FFFFFFF;
    localparam logic [31:0] SEB_CNT_MIN = 32'h80000000;
    localparam logic [31:0] SEB_ONE = 32'h00000001;
    localparam logic [31:0] SEB_ZERO = 32'h00000000;

    localparam logic [31:0] SEB_PRESET_RST = 32'h00000000;
    localparam logic [31:0] SEB_THRESH_RST = 32'h00000000;
    localparam logic [31:0] SEB_UNITS_RST = 32'h00000000;
    localparam logic [7:0] SEB_ENABLE_RST = 8'h00;
    localparam logic [15:0] SEB_MASK_RST = 16'h0000;

    localparam logic [11:0] SEB_OFS_ENABLE = 12'h000;
    localparam logic [11:0] SEB_OFS_IRQ_STAT = 12'h004;
    localparam logic [11:0] SEB_OFS_IRQ_MASK = 12'h008;
    localparam logic [11:0] SEB_OFS_FLAGS = 12'h00C;
    localparam logic [3:0] SEB_OFS_CH_PAGE = 4'h1;
    localparam logic [4:0] SEB_CH_PRESET = 5'h00;
    localparam logic [4:0] SEB_CH_THRESH = 5'h04;
    localparam logic [4:0] SEB_CH_UNITS = 5'h08;
    localparam logic [4:0] SEB_CH_COUNT = 5'h0C;
    localparam logic [4:0] SEB_CH_CAP_COUNT = 5'h10;
    localparam logic [4:0] SEB_CH_CAP_TS_LO = 5'h14;
    localparam logic [4:0] SEB_CH_CAP_TS_HI = 5'h18;

    localparam logic [1:0] SEB_NV_COUNT = 2'h0;
    localparam logic [1:0] SEB_NV_CAP = 2'h1;
    localparam logic [1:0] SEB_NV_TS_LO = 2'h2;
    localparam logic [1:0] SEB_NV_TS_HI = 2'h3;
    localparam logic [4:0] SEB_NV_LAST = 5'h1F;

    typedef struct packed {
        logic up;
        logic down;
        logic inhibit;
        logic load_initial_select;
        logic clear_cmd;
        logic capture_clear;
        logic capture_keep;
    } seb_cnt_in_t;

    typedef struct packed {
        logic count_above_threshold;
        logic count_matches_threshold;
        logic count_under_threshold;
    } seb_flags_t;

    typedef struct packed {
        logic we;
        logic [SEB_NV_AW-1:0] addr;
        logic [31:0] data;
    } seb_nv_word_t;

    typedef enum logic [2:0] {
        SEB_NV_IDLE = 3'b001,
        SEB_NV_SAVE = 3'b010,
        SEB_NV_DONE = 3'b100
    } seb_nv_fsm_t;

endpackage : seb_pkg

// file: seb_nv_save.sv
// Power-fail sequencer that streams counter values out to storage.
`timescale 1ns/1ps
module seb_nv_save (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic power_fail_i,
    input wire logic [31:0] word_i,
    output logic [seb_pkg::SEB_NV_AW-1:0] addr_o,
    output seb_pkg::seb_nv_word_t nv_o,
    output logic done_o
);
    import seb_pkg::*;

    typedef struct packed {
        seb_nv_fsm_t fsm;
        logic [SEB_NV_AW-1:0] idx;
        logic pf_prev;
        seb_nv_word_t out;
    } seb_nv_state_t;

    seb_nv_state_t st_r;
    seb_nv_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.pf_prev = power_fail_i;
        st_nxt.out.we = 1'b0;
        case (st_r.fsm)
            SEB_NV_IDLE: begin
                if (power_fail_i && !st_r.pf_prev) begin
                    st_nxt.fsm = SEB_NV_SAVE;
                    st_nxt.idx = '0;
                end
            end
            // [RULE_13] Stream every word once.
            SEB_NV_SAVE: begin
                st_nxt.out.we = 1'b1;
                st_nxt.out.addr = st_r.idx;
                st_nxt.out.data = word_i;
                st_nxt.idx = st_r.idx + 5'h01;
                if (st_r.idx == SEB_NV_LAST) begin
                    st_nxt.fsm = SEB_NV_DONE;
                end
            end
            SEB_NV_DONE: begin
                if (!power_fail_i) begin
                    st_nxt.fsm = SEB_NV_IDLE;
                end
            end
            default: begin
                st_nxt.fsm = SEB_NV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.fsm <= SEB_NV_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign addr_o = st_r.idx;
    assign nv_o = st_r.out;
    assign done_o = (st_r.fsm == SEB_NV_DONE);

endmodule : seb_nv_save

// file: seb_op_src.sv
// Operand source standing in for the logic that feeds the counters.
`timescale 1ns/1ps
module seb_op_src (
    input wire logic clk_i,
    input seb_pkg::seb_cnt_in_t [seb_pkg::SEB_NUM-1:0] want_i,
    output seb_pkg::seb_cnt_in_t [seb_pkg::SEB_NUM-1:0] cnt_in_o
);
    import seb_pkg::*;
    // common clock: operands change just after an edge.
    always_ff @(posedge clk_i) begin
        cnt_in_o <= want_i;
    end
endmodule : seb_op_src

// file: tb_top.sv
// Self-checking bench for the signed event counter bank.
`timescale 1ns/1ps
module tb_top;
    import seb_pkg::*;
    logic clk_i = 0;
    logic rst_i = 1;
    logic cyc = 0;
    logic we = 0;
    logic [11:0] adr = 0;
    logic [31:0] wd = 0, rd, mc, th, p, cp;
    logic [63:0] ts = 0;
    logic pf = 0;
    wire [31:0] dat_o;
    wire ack, irq, done;
    seb_cnt_in_t [SEB_NUM-1:0] want = '0;
    seb_cnt_in_t [SEB_NUM-1:0] cin;
    seb_flags_t [SEB_NUM-1:0] fl;
    seb_nv_word_t nvs;
    int err_count = 0, checks_done = 0, seed = 32'h141e37ff, ch, t, k;
    always #4 clk_i = ~clk_i;
    seb_op_src src_u (.clk_i(clk_i), .want_i(want), .cnt_in_o(cin));
    seb_counter_bank dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq),
        .cnt_in_i(cin), .timestamp_i(ts), .flags_o(fl),
        .power_fail_i(pf), .nv_save_o(nvs), .nv_save_done_o(done),
        .nv_restore_i('0));
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    task automatic chk(input string n, input logic [31:0] e, v);
        checks_done++;
        if (e !== v) begin
            err_count++;
            $display("wrong value %s exp %h got %h", n, e, v);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1;
        we <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = dat_o;
        cyc <= 0;
        if (ack !== 1'b1) begin
            err_count++;
            summarize();
        end
    endtask : wb
    task automatic rdc(input logic [4:0] o);
        wb(0, 12'h100 + 12'(ch * 32) + {7'h0, o}, 0);
    endtask : rdc
    task automatic pulse(input logic [6:0] m);
        @(posedge clk_i);
        want[ch] <= want[ch] | m;
        repeat (2) @(posedge clk_i);
        want[ch] <= want[ch] & ~m;
        repeat (3) @(posedge clk_i);
    endtask : pulse
    function automatic logic [31:0] flg(input logic [31:0] c);
        return {29'h0, $signed(c) > $signed(th), c == th,
                $signed(c) < $signed(th)};
    endfunction : flg
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        ch = $unsigned($random(seed)) % SEB_NUM;
        p = $random(seed);
        ts <= {$random(seed), $random(seed)};
        th = p + 1;
        wb(1, SEB_OFS_IRQ_MASK, 32'h1 << ch);
        wb(1, 12'h100 + 12'(ch * 32), p);
        wb(1, 12'h104 + 12'(ch * 32), th);
        @(posedge clk_i);
        want[ch].load_initial_select <= 1'b1;
        wb(1, SEB_OFS_ENABLE, 32'hFF);
        rdc(SEB_CH_COUNT); chk("count", p, rd); // enable
        pulse(7'h08); mc = p; chk("flags", flg(mc), fl[ch]);
        pulse(7'h40); mc++; chk("flags", flg(mc), fl[ch]);
        pulse(7'h40); mc++; chk("flags", flg(mc), fl[ch]);
        pulse(7'h60); rdc(SEB_CH_COUNT); chk("count", mc, rd);
        $display("test done: flags");
        wb(1, 12'h100 + 12'(ch * 32), SEB_CNT_MAX);
        pulse(7'h08); pulse(7'h40); rdc(SEB_CH_COUNT);
        chk("count", SEB_CNT_MIN, rd); // wrap up
        pulse(7'h20); rdc(SEB_CH_COUNT);
        chk("count", SEB_CNT_MAX, rd); // wrap down
        $display("test done: wrap");
        pulse(7'h01); rdc(SEB_CH_CAP_COUNT); cp = rd;
        chk("cap", SEB_CNT_MAX, cp); // capture keep
        rdc(SEB_CH_CAP_TS_LO); chk("ts", ts[31:0], rd);
        rdc(SEB_CH_COUNT); chk("count", SEB_CNT_MAX, rd);
        chk("irq", 1, {31'h0, irq}); // event flag
        wb(1, SEB_OFS_IRQ_STAT, 32'hFFFF);
        repeat (2) @(posedge clk_i);
        chk("irq", 0, {31'h0, irq}); // cleared
        pulse(7'h02); rdc(SEB_CH_COUNT); chk("count", 0, rd);
        pulse(7'h40); pulse(7'h04); rdc(SEB_CH_COUNT);
        chk("count", 0, rd); // reset zero
        $display("test done: capture");
        @(posedge clk_i);
        want[ch].inhibit <= 1'b1;
        pulse(7'h40); chk("flags", 0, fl[ch]); // blocked
        want[ch].inhibit <= 1'b0;
        rdc(SEB_CH_COUNT); chk("count", 0, rd); // no count
        wb(0, 12'hFF0, 0); chk("unmapped", 0, rd);
        $display("test done: inhibit");
        pf <= 1'b1;
        k = 0;
        for (t = 0; t < 100 && done !== 1'b1; t++) begin
            @(posedge clk_i);
            k += nvs.we;
            if (nvs.we && nvs.addr == {ch[2:0], 2'b01})
                chk("nv cap", SEB_CNT_MAX, nvs.data);
        end
        chk("nv words", 32, k);
        chk("nv done", 1, {31'h0, done});
        $display("test done: power save");
        summarize();
    end
endmodule : tb_top
